// file: src/hostport_defines.svh
`ifndef HOSTPORT_DEFINES_SVH
`define HOSTPORT_DEFINES_SVH

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define IDX_PIN_DATA 8'h09
`define IDX_DIR_STATUS 8'h89
`define IDX_ANALOG_CFG 8'h9f
`define IDX_HOST_DATA 8'ha0
`define IDX_IRQ_STATUS 8'ha1
`define IDX_IRQ_MASK 8'ha2

// ----------------------------------------
// Field positions of the direction and status register
// ----------------------------------------
`define BIT_INPUT_PENDING 7
`define BIT_OUTPUT_PENDING 6
`define BIT_OVERRUN 5
`define BIT_HOST_SELECT 4

// ----------------------------------------
// Interrupt status bit positions
// ----------------------------------------
`define IRQ_RECEIVED 0
`define IRQ_COLLECTED 1
`define IRQ_OVERRUN 2

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define DIR_STATUS_RESET 8'h07
`define DIR_RESET 3'h7
`define ANALOG_RESET 8'h00
`define ANALOG_WMASK 8'hcf

`endif

// file: src/hostport_pkg.sv
package hostport_pkg;

    // APB slave phase tracking
    typedef enum logic [0:0] {
        APB_IDLE,
        APB_DONE
    } apb_state_type;

endpackage : hostport_pkg

// file: src/bit_sync.sv
`timescale 1ns/10ps

module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_clk,              // System clock
    input wire logic i_rst,              // Synchronous reset, high
    input wire logic [WIDTH-1:0] i_async, // Pin levels
    output logic [WIDTH-1:0] o_sync      // Two-stage synchronised levels
);

    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) begin
            $error("bit_sync needs WIDTH of at least one");
        end
    end

    // First stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule : bit_sync

// file: src/strobe_decode.sv
`timescale 1ns/10ps

module strobe_decode (
    input wire logic i_clk,        // System clock
    input wire logic i_rst,        // Synchronous reset, high
    input wire logic i_enable,     // Host port selected
    input wire logic i_cs_n,       // Synchronised chip select, low
    input wire logic i_wr_n,       // Synchronised write strobe, low
    input wire logic i_rd_n,       // Synchronised read strobe, low
    output logic o_write_active,   // Host write strobe asserted
    output logic o_write_done,     // Pulse at end of host write
    output logic o_read_active,    // Host read strobe asserted
    output logic o_read_done       // Pulse at end of host read
);

    logic wr_now;
    logic rd_now;

    // Strobes only count while selected and chip select is low
    assign wr_now = i_enable & ~i_cs_n & ~i_wr_n;
    assign rd_now = i_enable & ~i_cs_n & ~i_rd_n;

    // Rising edge of an active-low strobe marks completion
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_write_active <= 1'b0;
            o_read_active <= 1'b0;
            o_write_done <= 1'b0;
            o_read_done <= 1'b0;
        end else begin
            o_write_active <= wr_now;
            o_read_active <= rd_now;
            o_write_done <= o_write_active & ~wr_now;
            o_read_done <= o_read_active & ~rd_now;
        end
    end

endmodule : strobe_decode

// file: src/hostport_top.sv
// Register access over APB was left to the implementer.
`timescale 1ns/10ps

`include "hostport_defines.svh"

module hostport_top
    import hostport_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic I_CLK,                     // 50 MHz system clock
    input wire logic I_RST,                     // Synchronous reset, high
    input wire logic I_PSEL,                    // APB select
    input wire logic I_PENABLE,                 // APB enable
    input wire logic I_PWRITE,                  // APB direction
    input wire logic [ADDR_WIDTH-1:0] I_PADDR,  // APB byte address
    input wire logic [31:0] I_PWDATA,           // APB write data
    output logic [31:0] O_PRDATA,               // APB read data
    output logic O_PREADY,                      // APB ready
    output logic O_PSLVERR,                     // Unmapped address
    input wire logic [2:0] I_PORT_E,            // Port E pin levels
    output logic [2:0] O_PORT_E,                // Port E drive value
    output logic [2:0] O_PORT_E_OE_N,           // Port E enable, low drives
    input wire logic [7:0] I_HOST_DATA,         // Port D pin levels
    output logic [7:0] O_HOST_DATA,             // Port D drive value
    output logic [7:0] O_HOST_DATA_OE_N,        // Port D enable, low drives
    output logic O_IRQ                          // Level interrupt
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    initial begin
        if (ADDR_WIDTH < 10 || ADDR_WIDTH > 32) begin
            $error("hostport_top needs ADDR_WIDTH from 10 to 32");
        end
    end

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    apb_state_type apb_state_q;
    logic [2:0] dir_q;
    logic input_word_pending_q;
    logic output_word_pending_q;
    logic input_overrun_flag_q;
    logic host_port_select_q;
    logic [2:0] port_e_pin_data_q;
    logic [7:0] analog_cfg_q;
    logic [7:0] in_word_q;
    logic [7:0] out_word_q;
    logic [7:0] capture_q;
    logic [2:0] irq_status_q;
    logic [2:0] irq_mask_q;
    logic [2:0] pin_e_sync;
    logic [7:0] host_data_sync;
    logic write_active;
    logic write_done;
    logic read_active;
    logic read_done;
    logic commit;
    logic wr_commit;
    logic rd_commit;
    logic [7:0] dir_status_rd;
    logic [31:0] rdata_d;
    logic mapped_d;

    // Register index match, shared by read mux and write strobes
    function automatic logic reg_hit(input logic [ADDR_WIDTH-1:0] addr, input logic [7:0] idx);
        reg_hit = (addr[1:0] == 2'b00) && (addr[9:2] == idx) && ((addr >> 10) == '0);
    endfunction : reg_hit

    // ----------------------------------------
    // Pin synchronisers and strobe decode
    // ----------------------------------------
    // Idle strobes are high, so reset the port E stages high
    bit_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_sync_port_e (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_async(I_PORT_E),
        .o_sync(pin_e_sync)
    );

    bit_sync #(.WIDTH(8), .RESET_VAL(8'h00)) u_sync_host_data (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_async(I_HOST_DATA),
        .o_sync(host_data_sync)
    );

    // Pin 0 read strobe, pin 1 write strobe, pin 2 chip select
    strobe_decode u_strobe (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_enable(host_port_select_q),
        .i_cs_n(pin_e_sync[2]),
        .i_wr_n(pin_e_sync[1]),
        .i_rd_n(pin_e_sync[0]),
        .o_write_active(write_active),
        .o_write_done(write_done),
        .o_read_active(read_active),
        .o_read_done(read_done)
    );

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Ready one cycle into access; effects land only on that edge
    assign commit = (apb_state_q == APB_DONE) & I_PSEL & I_PENABLE;
    assign wr_commit = commit & I_PWRITE & mapped_d;
    assign rd_commit = commit & ~I_PWRITE & mapped_d;

    // Bit 3 is always zero on read
    assign dir_status_rd = {input_word_pending_q, output_word_pending_q, input_overrun_flag_q,
                            host_port_select_q, 1'b0, dir_q};

    // Read mux and decode
    always_comb begin
        rdata_d = 32'h0000_0000;
        mapped_d = 1'b1;
        if (reg_hit(I_PADDR, `IDX_PIN_DATA)) begin
            rdata_d = {29'h0, pin_e_sync};
        end else if (reg_hit(I_PADDR, `IDX_DIR_STATUS)) begin
            rdata_d = {24'h0, dir_status_rd};
        end else if (reg_hit(I_PADDR, `IDX_ANALOG_CFG)) begin
            rdata_d = {24'h0, analog_cfg_q};
        end else if (reg_hit(I_PADDR, `IDX_HOST_DATA)) begin
            rdata_d = {24'h0, in_word_q};
        end else if (reg_hit(I_PADDR, `IDX_IRQ_STATUS)) begin
            rdata_d = {29'h0, irq_status_q};
        end else if (reg_hit(I_PADDR, `IDX_IRQ_MASK)) begin
            rdata_d = {29'h0, irq_mask_q};
        end else begin
            mapped_d = 1'b0;
        end
    end

    // Two-state handshake keeps every bus output on a flop
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            apb_state_q <= APB_IDLE;
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else begin
            case (apb_state_q)
                APB_IDLE: begin
                    if (I_PSEL && I_PENABLE) begin
                        apb_state_q <= APB_DONE;
                        O_PREADY <= 1'b1;
                        O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rdata_d;
                        O_PSLVERR <= ~mapped_d;
                    end
                end
                APB_DONE: begin
                    apb_state_q <= APB_IDLE;
                    O_PREADY <= 1'b0;
                    O_PRDATA <= 32'h0000_0000;
                    O_PSLVERR <= 1'b0;
                end
                default: begin
                    apb_state_q <= APB_IDLE;
                    O_PREADY <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Direction and mode bits
    // ----------------------------------------
    // Pending flags are not written here; bit 3 has no storage
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            dir_q <= `DIR_RESET;
            host_port_select_q <= 1'b0;
        end else if (wr_commit && reg_hit(I_PADDR, `IDX_DIR_STATUS)) begin
            dir_q <= I_PWDATA[2:0];
            host_port_select_q <= I_PWDATA[`BIT_HOST_SELECT];
        end
    end

    // Analog pin layout storage only, unused bits read zero
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            analog_cfg_q <= `ANALOG_RESET;
        end else if (wr_commit && reg_hit(I_PADDR, `IDX_ANALOG_CFG)) begin
            analog_cfg_q <= I_PWDATA[7:0] & `ANALOG_WMASK;
        end
    end

    // ----------------------------------------
    // Port E data latch and pin drive
    // ----------------------------------------
    // No reset: contents survive every reset, unknown at power-up
    always_ff @(posedge I_CLK) begin
        if (wr_commit && reg_hit(I_PADDR, `IDX_PIN_DATA)) begin
            port_e_pin_data_q <= I_PWDATA[2:0];
        end
    end

    // A one in the direction bit releases the pin
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_PORT_E_OE_N <= 3'h7;
            O_PORT_E <= 3'h0;
        end else begin
            O_PORT_E_OE_N <= dir_q;
            O_PORT_E <= port_e_pin_data_q & ~dir_q;
        end
    end

    // ----------------------------------------
    // Host port data path
    // ----------------------------------------
    // Keep the last value seen under the write strobe
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            capture_q <= 8'h00;
        end else if (write_active) begin
            capture_q <= host_data_sync;
        end
    end

    // Word commits at the end of the host write, overrun overwrites; CPU read clears, set wins on a tie
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            in_word_q <= 8'h00;
            input_word_pending_q <= 1'b0;
        end else if (write_done) begin
            in_word_q <= capture_q;
            input_word_pending_q <= 1'b1;
        end else if (rd_commit && reg_hit(I_PADDR, `IDX_HOST_DATA)) begin
            input_word_pending_q <= 1'b0;
        end
    end

    // Sticky until software writes zero; host event wins
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            input_overrun_flag_q <= 1'b0;
        end else if (write_done && input_word_pending_q) begin
            input_overrun_flag_q <= 1'b1;
        end else if (wr_commit && reg_hit(I_PADDR, `IDX_DIR_STATUS)) begin
            input_overrun_flag_q <= I_PWDATA[`BIT_OVERRUN];
        end
    end

    // CPU write loads the word and sets pending, host read end clears; set wins on a tie
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            out_word_q <= 8'h00;
            output_word_pending_q <= 1'b0;
        end else if (wr_commit && reg_hit(I_PADDR, `IDX_HOST_DATA)) begin
            out_word_q <= I_PWDATA[7:0];
            output_word_pending_q <= 1'b1;
        end else if (read_done) begin
            output_word_pending_q <= 1'b0;
        end
    end

    // Drive port D only while the host reads; else left to plain I/O
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_HOST_DATA_OE_N <= 8'hff;
            O_HOST_DATA <= 8'h00;
        end else begin
            O_HOST_DATA_OE_N <= read_active ? 8'h00 : 8'hff;
            O_HOST_DATA <= read_active ? out_word_q : 8'h00;
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            irq_status_q <= 3'h0;
        end else begin
            if (wr_commit && reg_hit(I_PADDR, `IDX_IRQ_STATUS)) begin
                irq_status_q <= (irq_status_q & ~I_PWDATA[2:0])
                    | {write_done & input_word_pending_q, read_done, write_done};
            end else begin
                irq_status_q <= irq_status_q | {write_done & input_word_pending_q, read_done, write_done};
            end
        end
    end

    // Mask is a plain enable per status bit
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            irq_mask_q <= 3'h0;
        end else if (wr_commit && reg_hit(I_PADDR, `IDX_IRQ_MASK)) begin
            irq_mask_q <= I_PWDATA[2:0];
        end
    end

    // Registered so the output comes from a flop; one cycle late
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= |(irq_status_q & irq_mask_q);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_input_pending_set: assert property (
        @(posedge I_CLK) disable iff (I_RST) write_done |=> input_word_pending_q)
        else $error("input pending not set after host write");
    a_output_pending_hold: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        (output_word_pending_q && !read_done) |=> output_word_pending_q)
        else $error("output pending dropped without host read");
    a_output_pending_clear: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        (read_done && !(wr_commit && reg_hit(I_PADDR, `IDX_HOST_DATA))) |=> !output_word_pending_q)
        else $error("output pending not cleared after host read");
    a_overrun_sticky: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        (write_done && input_word_pending_q) |=> input_overrun_flag_q)
        else $error("overrun not flagged");
    a_select_gates_port: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        !host_port_select_q [*3] |=> O_HOST_DATA_OE_N == 8'hff)
        else $error("port D driven while host port off");
    a_bit3_reads_zero: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        (O_PREADY && $past(reg_hit(I_PADDR, `IDX_DIR_STATUS)) && !$past(I_PWRITE)) |-> !O_PRDATA[3])
        else $error("bit 3 read as one");
    a_dir_drives_pins: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        (wr_commit && reg_hit(I_PADDR, `IDX_DIR_STATUS)) |=> ##1 O_PORT_E_OE_N == $past(I_PWDATA[2:0], 2))
        else $error("direction write not reflected on pins");
    a_reset_values: assert property (
        @(posedge I_CLK) $past(I_RST) |-> (dir_status_rd == `DIR_STATUS_RESET))
        else $error("direction and status reset value wrong");
    a_flags_read_only: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        (wr_commit && reg_hit(I_PADDR, `IDX_DIR_STATUS) && !write_done && !read_done)
        |=> $stable(input_word_pending_q) && $stable(output_word_pending_q))
        else $error("pending flag changed by software write");
    a_pin_data_kept: assert property (
        @(posedge I_CLK) $rose(I_RST) |=> $stable(port_e_pin_data_q))
        else $error("port E latch changed by reset");

endmodule : hostport_top

// file: verif/host_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// External host on the slave port
// ----------------------------------------
module host_model (
    input wire logic i_clk,            // System clock
    input wire logic [2:0] i_pe_drive, // Device port E drive
    input wire logic [2:0] i_pe_oe_n,  // Device port E enable, low drives
    input wire logic [7:0] i_pd_drive, // Device port D drive
    input wire logic [7:0] i_pd_oe_n,  // Device port D enable, low drives
    output logic [2:0] o_pe_pin,       // Resolved port E levels
    output logic [7:0] o_pd_pin        // Resolved port D levels
);
    logic [2:0] strobe_n_q = 3'h7; // Chip select, write, read; idle high
    logic [7:0] data_q = 8'h00;
    logic drive_q = 1'b0;

    // Device wins where it drives; a released bus shows the inverse of the last word
    assign o_pe_pin = (i_pe_oe_n & strobe_n_q) | (~i_pe_oe_n & i_pe_drive);
    assign o_pd_pin = (~i_pd_oe_n & i_pd_drive) | (i_pd_oe_n & (drive_q ? data_q : ~data_q));

    // Data settles with the strobes and stays three cycles past their rise
    task automatic write_word(input logic [7:0] word, input int hold);
        @(posedge i_clk);
        data_q <= word;
        drive_q <= 1'b1;
        strobe_n_q <= 3'b001;
        repeat (hold) @(posedge i_clk);
        strobe_n_q <= 3'h7;
        repeat (3) @(posedge i_clk);
        drive_q <= 1'b0;
    endtask : write_word

    // Hold must cover the synchroniser plus the device's turn-on delay
    task automatic read_word(output logic [7:0] word, input int hold);
        @(posedge i_clk);
        strobe_n_q <= 3'b010;
        repeat (hold) @(posedge i_clk);
        word = o_pd_pin;
        strobe_n_q <= 3'h7;
    endtask : read_word
endmodule : host_model

// file: verif/test_port_e_direction_host_port_status.sv
`timescale 1ns/10ps

`include "hostport_defines.svh"

module test_port_e_direction_host_port_status;
    import hostport_pkg::*;

    logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, w, lat, r;
    logic [2:0] pe_pin, pe_drive, pe_oe_n;
    logic [7:0] pd_pin, pd_drive, pd_oe_n, hw;
    int fail_count, comparisons;

    hostport_top hostport_top_i (
        .I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_PORT_E(pe_pin), .O_PORT_E(pe_drive), .O_PORT_E_OE_N(pe_oe_n),
        .I_HOST_DATA(pd_pin), .O_HOST_DATA(pd_drive), .O_HOST_DATA_OE_N(pd_oe_n), .O_IRQ(irq)
    );

    host_model host_model_i (
        .i_clk(clk), .i_pe_drive(pe_drive), .i_pe_oe_n(pe_oe_n),
        .i_pd_drive(pd_drive), .i_pd_oe_n(pd_oe_n), .o_pe_pin(pe_pin), .o_pd_pin(pd_pin)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : next_rand

    // Status bits from the hardware, control bits as written, bit three zero
    function automatic logic [31:0] dir_exp(input logic [7:0] wv, input logic [1:0] pend, input logic ov);
        return {24'h00_0000, pend, wv[5] | ov, wv[4], 1'b0, wv[2:0]};
    endfunction : dir_exp

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One transfer; an idle edge after release avoids double assignment
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fail_count++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic reg_wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] rv;
        logic ev;
        apb(1'b1, {2'b00, idx, 2'b00}, d, rv, ev);
    endtask : reg_wr

    task automatic reg_rd(input string name, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rv;
        logic ev;
        apb(1'b0, {2'b00, idx, 2'b00}, 32'h0000_0000, rv, ev);
        check(name, exp, rv);
    endtask : reg_rd

    // ----------------------------------------
    // Clock and main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        {fail_count, comparisons, seed} = {32'h0, 32'h0, 32'h0000_c28a};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reg_rd("dir_reset", `IDX_DIR_STATUS, 32'h07);
        reg_rd("analog_reset", `IDX_ANALOG_CFG, 32'h00);
        check("oe_reset", 32'h7, pe_oe_n);
        // Random directions with host port off; pins left as outputs carry the latch
        for (int i = 0; i < 6; i++) begin
            w = (i == 0) ? 32'hef : next_rand() & 32'hef;
            lat = next_rand();
            reg_wr(`IDX_PIN_DATA, lat);
            reg_wr(`IDX_DIR_STATUS, w);
            reg_rd("dir_rw", `IDX_DIR_STATUS, dir_exp(w[7:0], 2'b00, 1'b0));
            check("pe_oe_n", w[2:0], pe_oe_n);
            check("pe_drive", ~w[2:0] & lat[2:0], pe_drive);
            reg_rd("pin_levels", `IDX_PIN_DATA, w[2:0] | lat[2:0]);
        end
        // A second reset restores status but keeps the latch
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reg_rd("dir_rereset", `IDX_DIR_STATUS, 32'h07);
        reg_wr(`IDX_DIR_STATUS, 32'h00);
        // Pin drive register follows one edge after the direction bits
        @(posedge clk);
        check("latch_kept", lat[2:0], pe_drive);
        // Release the pins before selecting the host port, so driven levels never look like strobes
        reg_wr(`IDX_DIR_STATUS, 32'h07);
        // Host writes, the second onto an unread word
        reg_wr(`IDX_IRQ_MASK, 32'h7);
        reg_wr(`IDX_DIR_STATUS, 32'h17);
        w = next_rand();
        host_model_i.write_word(w[7:0], 3);
        repeat (4) @(posedge clk);
        check("irq_rx", 32'h1, irq);
        reg_rd("in_pending", `IDX_DIR_STATUS, dir_exp(8'h17, 2'b10, 1'b0));
        w = next_rand();
        host_model_i.write_word(w[7:0], 6);
        repeat (4) @(posedge clk);
        reg_rd("overrun", `IDX_DIR_STATUS, dir_exp(8'h17, 2'b10, 1'b1));
        reg_rd("host_word", `IDX_HOST_DATA, w[7:0]);
        reg_rd("in_cleared", `IDX_DIR_STATUS, dir_exp(8'h17, 2'b00, 1'b1));
        reg_wr(`IDX_DIR_STATUS, 32'hff);
        reg_rd("ro_bits", `IDX_DIR_STATUS, dir_exp(8'hff, 2'b00, 1'b0));
        reg_wr(`IDX_DIR_STATUS, 32'h17);
        reg_rd("ov_cleared", `IDX_DIR_STATUS, 32'h17);
        // CPU word waits, then the host collects it
        w = next_rand();
        reg_wr(`IDX_HOST_DATA, w);
        reg_rd("out_pending", `IDX_DIR_STATUS, dir_exp(8'h17, 2'b01, 1'b0));
        repeat (20) @(posedge clk);
        reg_rd("out_held", `IDX_DIR_STATUS, dir_exp(8'h17, 2'b01, 1'b0));
        host_model_i.read_word(hw, 8);
        check("host_read", w[7:0], hw);
        repeat (6) @(posedge clk);
        reg_rd("out_done", `IDX_DIR_STATUS, 32'h17);
        reg_rd("irq_status", `IDX_IRQ_STATUS, 32'h7);
        reg_wr(`IDX_IRQ_STATUS, 32'h7);
        reg_rd("irq_cleared", `IDX_IRQ_STATUS, 32'h0);
        check("irq_low", 32'h0, irq);
        // Masked event stays quiet until unmasked
        reg_wr(`IDX_IRQ_MASK, 32'h0);
        w = next_rand();
        host_model_i.write_word(w[7:0], 4);
        repeat (4) @(posedge clk);
        check("irq_masked", 32'h0, irq);
        reg_wr(`IDX_IRQ_MASK, 32'h1);
        @(posedge clk);
        check("irq_unmasked", 32'h1, irq);
        reg_rd("host_word2", `IDX_HOST_DATA, w[7:0]);
        reg_wr(`IDX_IRQ_STATUS, 32'h7);
        // Host port off: strobes ignored
        reg_wr(`IDX_DIR_STATUS, 32'h07);
        host_model_i.write_word(8'h5a, 4);
        repeat (4) @(posedge clk);
        reg_rd("plain_io", `IDX_DIR_STATUS, 32'h07);
        reg_rd("plain_irq", `IDX_IRQ_STATUS, 32'h0);
        apb(1'b0, 12'h000, 32'h0000_0000, r, e);
        check("unmapped_err", 32'h1, e);
        check("unmapped_data", 32'h0, r);
        test_done();
    end
endmodule : test_port_e_direction_host_port_status
